// file: design/mbwmr_fifo.sv
`timescale 1ns/1ps
module mbwmr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb
  begin
    push = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
    pop  = out_ready_i && (cnt_q != '0);
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wp_q] <= in_data_i;
  end

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rp_q];
endmodule // mbwmr_fifo

// file: design/mbwmr_pkg.sv
package mbwmr_pkg;
  localparam logic [7:0]  FUNC_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  UNIT_ID_ZERO     = 8'h00;
  localparam logic [7:0]  UNIT_ID_ALL      = 8'hFF;
  localparam logic [15:0] PROTO_ID_MODBUS  = 16'h0000;
  localparam logic [15:0] RESP_LENGTH      = 16'h0006;
  localparam logic [15:0] QTY_MAX          = 16'h007D;
  localparam logic [7:0]  BYTE_COUNT_MIN   = 8'h02;
  localparam logic [7:0]  BYTE_COUNT_MAX   = 8'hFA;
  localparam logic [15:0] LEN_FIXED_PART   = 16'h0007;
  localparam logic [3:0]  HDR_BYTES        = 4'hD;
  localparam logic [3:0]  RESP_BYTES       = 4'hC;
  localparam int          FIFO_DEPTH       = 32;
  localparam int          FIFO_WIDTH       = 32;
  typedef enum logic [2:0] {ST_HDR, ST_DATA, ST_DRAIN, ST_RESP, ST_SKIP} mbwmr_state_e;
endpackage

// file: design/mbwmr_top.sv
// Notes on behaviour
// - Function 0x10 writes consecutive registers, one word each.
// - Transaction tag copied unchanged into response.
// - Nonzero protocol id: no response; reply uses zero.
// - Length counts unit id through last data byte.
// - Start address is register number minus 40001.
// - Data holds exactly quantity words.
// - Words high byte first, ascending addresses.
// - Response echoes header with length set to 6, function, start, quantity.
`timescale 1ns/1ps
module mbwmr_top
  import mbwmr_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_LAST_I,
  output logic             RX_READY_O,
  output logic             TX_VALID_O,
  output logic [7:0]       TX_DATA_O,
  output logic             TX_LAST_O,
  input  wire logic        TX_READY_I,
  output logic             REG_WE_O,
  output logic [15:0]      REG_ADDR_O,
  output logic [15:0]      REG_DATA_O,
  input  wire logic        REG_READY_I,
  output logic             QUERY_DROP_O
);
  mbwmr_state_e     st_q, st_d;
  logic [7:0]       hdr_q [HDR_BYTES], hdr_d [HDR_BYTES];
  logic [3:0]       idx_q, idx_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [7:0]       hi_q, hi_d;
  logic [15:0]      wa_q, wa_d;
  logic             drop_q, drop_d;
  logic             tv_q, tv_d, tl_q, tl_d;
  logic [7:0]       td_q, td_d;
  logic             f_in_valid, f_in_ready, f_out_valid;
  logic [31:0]      f_in_data, f_out_data;
  logic             rx_take, hdr_ok;
  logic [15:0]      proto, len, qty;
  logic [7:0]       bcnt;
  logic             we_q, we_d;
  logic [15:0]      ra_q, ra_d, rd_q, rd_d;

  mbwmr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (!we_q || REG_READY_I),
    .out_data_o  (f_out_data)
  );

  always_comb
  begin
    proto = {hdr_q[2], hdr_q[3]};
    len   = {hdr_q[4], hdr_q[5]};
    qty   = {hdr_q[10], hdr_q[11]};
    bcnt  = hdr_q[12];
    // Checks run on the completed header before any data is taken.
    hdr_ok = (proto == PROTO_ID_MODBUS)
          && (hdr_q[6] == UNIT_ID_ZERO || hdr_q[6] == UNIT_ID_ALL)
          && (hdr_q[7] == FUNC_WRITE_MULTI)
          && (qty != 16'h0000) && (qty <= QTY_MAX)
          && (bcnt >= BYTE_COUNT_MIN) && (bcnt <= BYTE_COUNT_MAX)
          && ({qty[7:0], 1'b0} == bcnt) && (qty[15:7] == '0)
          && (len == LEN_FIXED_PART + {8'h00, bcnt});
  end

  always_comb
  begin
    st_d = st_q;
    hdr_d = hdr_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    hi_d = hi_q;
    wa_d = wa_q;
    drop_d = 1'b0;
    tv_d = tv_q;
    td_d = td_q;
    tl_d = tl_q;
    f_in_valid = 1'b0;
    f_in_data = {wa_q, hi_q, 8'h00};
    RX_READY_O = 1'b0;
    rx_take = 1'b0;
    case (st_q)
      ST_HDR:
      begin
        // The checking cycle after the thirteenth byte takes no data byte.
        RX_READY_O = idx_q != HDR_BYTES;
        rx_take = RX_VALID_I && RX_READY_O;
        if (rx_take && idx_q != HDR_BYTES)
        begin
          hdr_d[idx_q] = RX_DATA_I;
          idx_d = idx_q + 4'h1;
          if (RX_LAST_I)
          begin
            idx_d = '0;
            drop_d = 1'b1;
          end
        end
        else if (idx_q == HDR_BYTES)
        begin
          idx_d = '0;
          cnt_d = '0;
          wa_d = {hdr_q[8], hdr_q[9]};
          if (hdr_ok)
            st_d = ST_DATA;
          else
          begin
            st_d = ST_SKIP;
            drop_d = 1'b1;
          end
        end
      end
      ST_DATA:
      begin
        // Data bytes are counted; the odd byte joins its high byte.
        RX_READY_O = cnt_q[0] ? f_in_ready : 1'b1;
        rx_take = RX_VALID_I && RX_READY_O;
        if (rx_take)
        begin
          cnt_d = cnt_q + 8'h01;
          if (!cnt_q[0])
            hi_d = RX_DATA_I;
          else
          begin
            f_in_valid = 1'b1;
            f_in_data = {wa_q, hi_q, RX_DATA_I};
            wa_d = wa_q + 16'h0001;
          end
          if (cnt_d == hdr_q[12] && RX_LAST_I)
            st_d = ST_DRAIN;
          else if (RX_LAST_I || cnt_d == hdr_q[12])
          begin
            st_d = RX_LAST_I ? ST_HDR : ST_SKIP;
            drop_d = 1'b1;
          end
        end
      end
      ST_DRAIN:
        if (!f_out_valid && !we_q)
        begin
          st_d = ST_RESP;
          idx_d = '0;
        end
      ST_RESP:
        if (!tv_q || TX_READY_I)
        begin
          if (idx_q == RESP_BYTES)
          begin
            tv_d = 1'b0;
            tl_d = 1'b0;
            idx_d = '0;
            st_d = ST_HDR;
          end
          else
          begin
            tv_d = 1'b1;
            tl_d = idx_q == RESP_BYTES - 4'h1;
            idx_d = idx_q + 4'h1;
            case (idx_q)
              4'h2, 4'h3: td_d = 8'h00;
              4'h4: td_d = RESP_LENGTH[15:8];
              4'h5: td_d = RESP_LENGTH[7:0];
              default: td_d = hdr_q[idx_q];
            endcase
          end
        end
      ST_SKIP:
      begin
        RX_READY_O = 1'b1;
        rx_take = RX_VALID_I;
        if (rx_take && RX_LAST_I)
          st_d = ST_HDR;
      end
      default: st_d = ST_HDR;
    endcase
  end

  // One stored word reaches the register port per accepted handshake.
  always_comb
  begin
    we_d = we_q;
    ra_d = ra_q;
    rd_d = rd_q;
    if (!we_q || REG_READY_I)
    begin
      we_d = f_out_valid;
      ra_d = f_out_data[31:16];
      rd_d = f_out_data[15:0];
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      st_q <= ST_HDR;
      for (int i = 0; i < HDR_BYTES; i++)
        hdr_q[i] <= 8'h00;
      idx_q <= '0;
      cnt_q <= '0;
      hi_q <= '0;
      wa_q <= '0;
      drop_q <= 1'b0;
      tv_q <= 1'b0;
      td_q <= '0;
      tl_q <= 1'b0;
      we_q <= 1'b0;
      ra_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      hdr_q <= hdr_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      wa_q <= wa_d;
      drop_q <= drop_d;
      tv_q <= tv_d;
      td_q <= td_d;
      tl_q <= tl_d;
      we_q <= we_d;
      ra_q <= ra_d;
      rd_q <= rd_d;
    end
  end

  assign TX_VALID_O = tv_q;
  assign TX_DATA_O = td_q;
  assign TX_LAST_O = tl_q;
  assign REG_WE_O = we_q;
  assign REG_ADDR_O = ra_q;
  assign REG_DATA_O = rd_q;
  assign QUERY_DROP_O = drop_q;
endmodule // mbwmr_top

// file: test/mbwmr_client.sv
`timescale 1ns/1ps
module mbwmr_client (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_last_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] rsp_q[$];
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Each byte stands until taken; idle data shows the inverse of the last byte.
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i])
    begin
      rx_valid_o <= 1'b1;
      rx_data_o <= f[i];
      rx_last_o <= (i == f.size() - 1);
      do @(posedge clk_i); while (!rx_ready_i);
      #1;
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~f[f.size() - 1];
  endtask
  // The reply is taken only every other cycle.
  always @(posedge clk_i)
  begin
    if (tx_valid_i && tx_ready_o) rsp_q.push_back(tx_data_i);
    tx_ready_o <= #1 ~tx_ready_o;
  end
endmodule // mbwmr_client

// file: test/mbwmr_props.sv
`timescale 1ns/1ps
module mbwmr_props
  import mbwmr_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        RX_READY_O,
  input wire logic        TX_VALID_O,
  input wire logic [7:0]  TX_DATA_O,
  input wire logic        TX_LAST_O,
  input wire logic        TX_READY_I,
  input wire logic        REG_WE_O,
  input wire logic [15:0] REG_ADDR_O,
  input wire logic [15:0] REG_DATA_O,
  input wire logic        REG_READY_I,
  input wire logic        QUERY_DROP_O
);
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Counts response bytes taken so far in the current reply.
  always_comb
  begin
    idx_d = idx_q;
    if (TX_VALID_O && TX_READY_I)
    begin
      idx_d = TX_LAST_O ? 4'h0 : idx_q + 4'h1;
    end
  end
  always_ff @(posedge REF_CLK_I)
  begin
    idx_q <= RST_N_I ? idx_d : 4'h0;
  end
  we_hold_a: assert property (REG_WE_O && !REG_READY_I |=> REG_WE_O && $stable(REG_ADDR_O) && $stable(REG_DATA_O))
    else $error("write request dropped early");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O))
    else $error("response byte changed early");
  rx_block_a: assert property (TX_VALID_O |-> !RX_READY_O)
    else $error("query taken during reply");
  drop_once_a: assert property (QUERY_DROP_O |=> !QUERY_DROP_O)
    else $error("drop pulse too long");
  drop_quiet_a: assert property (QUERY_DROP_O |-> !TX_VALID_O)
    else $error("reply for dropped query");
  tx_len_a: assert property (TX_VALID_O && TX_LAST_O |-> idx_q == 4'hB)
    else $error("reply not twelve bytes");
  proto_zero_a: assert property (TX_VALID_O && idx_q inside {4'h2, 4'h3, 4'h4} |-> TX_DATA_O == 8'h00)
    else $error("reply protocol or length high nonzero");
  len_six_a: assert property (TX_VALID_O && idx_q == 4'h5 |-> TX_DATA_O == RESP_LENGTH[7:0])
    else $error("reply length wrong");
  func_echo_a: assert property (TX_VALID_O && idx_q == 4'h7 |-> TX_DATA_O == FUNC_WRITE_MULTI)
    else $error("reply function wrong");
  cover property (TX_VALID_O && TX_LAST_O && TX_READY_I);
  cover property (QUERY_DROP_O);
  cover property (REG_WE_O && !REG_READY_I);
endmodule // mbwmr_props
bind mbwmr_top mbwmr_props u_props (.*);

// file: test/mbwmr_top_bench.sv
`timescale 1ns/1ps
module mbwmr_top_bench;
  import mbwmr_pkg::*;
  logic REF_CLK_I, RST_N_I, RX_VALID_I, RX_LAST_I, RX_READY_O, TX_VALID_O, TX_LAST_O, TX_READY_I;
  logic REG_WE_O, REG_READY_I, QUERY_DROP_O;
  logic [7:0] RX_DATA_I, TX_DATA_O;
  logic [15:0] REG_ADDR_O, REG_DATA_O;
  logic [7:0] fr[$], exp[$];
  logic [15:0] wa[$], wd[$];
  int errors, check_count, cyc, drops;
  bit stall;
  mbwmr_top u_dut (.*);
  mbwmr_client u_cli (.clk_i(REF_CLK_I), .rx_ready_i(RX_READY_O), .rx_valid_o(RX_VALID_I),
    .rx_data_o(RX_DATA_I), .rx_last_o(RX_LAST_I), .tx_valid_i(TX_VALID_O), .tx_data_i(TX_DATA_O),
    .tx_ready_o(TX_READY_I));
  initial
  begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I)
  begin
    cyc++;
    if (QUERY_DROP_O) drops++;
    if (REG_WE_O && REG_READY_I)
    begin
      wa.push_back(REG_ADDR_O);
      wd.push_back(REG_DATA_O);
    end
    REG_READY_I <= #1 !stall || cyc[1:0] == 0;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, want);
    end
  endtask
  function automatic void mk(logic [15:0] tag, pid, logic [7:0] unit, logic [15:0] addr, int qty, int bx);
    logic [7:0] bc;
    logic [15:0] ln, q;
    bc = 8'(2 * qty + bx);
    ln = 16'(7) + 16'(bc);
    q = 16'(qty);
    fr = {tag[15:8], tag[7:0], pid[15:8], pid[7:0], ln[15:8], ln[7:0], unit, FUNC_WRITE_MULTI,
      addr[15:8], addr[7:0], q[15:8], q[7:0], bc};
    for (int i = 0; i < qty; i++) fr = {fr, 8'hA5, 8'(i)};
    exp = {fr[0:3], 8'h00, 8'h06, fr[6:11]};
  endfunction
  task automatic t_ok(input logic [15:0] tag, input logic [7:0] unit, input logic [15:0] addr, input int qty,
    input bit st);
    int n;
    stall = st;
    wa.delete();
    wd.delete();
    u_cli.rsp_q.delete();
    mk(tag, 16'h0000, unit, addr, qty, 0);
    u_cli.send(fr);
    n = 0;
    while (u_cli.rsp_q.size() < 12 && n < 3000)
    begin
      @(posedge REF_CLK_I);
      n++;
    end
    #1;
    chk(16'(wa.size()), 16'(qty));
    foreach (wa[i]) chk(wa[i], addr + 16'(i));
    foreach (wd[i]) chk(wd[i], 16'hA500 + 16'(i));
    foreach (exp[i]) chk({8'h00, u_cli.rsp_q[i]}, {8'h00, exp[i]});
  endtask
  task automatic t_bad(input logic [15:0] pid, input int bx);
    int d0;
    d0 = drops;
    wa.delete();
    u_cli.rsp_q.delete();
    mk(16'h5A5A, pid, 8'hFF, 16'h0010, 2, bx);
    u_cli.send(fr);
    repeat (40) @(posedge REF_CLK_I);
    chk(16'(drops - d0), 16'h0001);
    chk(16'(u_cli.rsp_q.size() + wa.size()), 16'h0000);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    RST_N_I = 1'b0;
    stall = 1'b0;
    REG_READY_I = 1'b0;
    repeat (16) @(posedge REF_CLK_I);
    #1 RST_N_I = 1'b1;
    t_ok(16'h1234, 8'hFF, 16'h03EE, 2, 1'b0);
    t_bad(16'h0001, 0);
    t_ok(16'hBEEF, 8'h00, 16'h0100, 125, 1'b1);
    t_bad(16'h0000, 2);
    give_verdict;
  end
endmodule // mbwmr_top_bench
